// [hw/pcg_map.svh]
`ifndef PCG_MAP_SVH
`define PCG_MAP_SVH

// ------------------------------------------------------------
// Register word offsets (byte addresses)
// ------------------------------------------------------------
`define PCG_REG_CFG      8'h00
`define PCG_REG_STAT     8'h04
`define PCG_REG_CTRL_POS 8'h08
`define PCG_REG_SIG_TX   8'h0C
`define PCG_REG_CTRL_RX  8'h10
`define PCG_GRP_VPOS     4'h2
`define PCG_GRP_VTX      4'h3
`define PCG_GRP_VRX      4'h4

// ------------------------------------------------------------
// Configuration fields and reset values
// ------------------------------------------------------------
`define PCG_CFG_CTRL_EN   0
`define PCG_CFG_CTRL_KIND 1
`define PCG_CFG_INACTIVE  2
`define PCG_CFG_DISC      3
`define PCG_CFG_DCL_X2    4
`define PCG_CFG_LIN_LSB   8
`define PCG_CFG_SEC_LSB   12
`define PCG_CFG_RESET     16'h0004

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define PCG_SYS_MHZ       200
`define PCG_DET_WIN_NS    250000
`define PCG_DET_WIN_CYC   (`PCG_DET_WIN_NS * `PCG_SYS_MHZ / 1000)
`define PCG_MIN_CLK_EDGES 32
`define PCG_MAX_FS_EDGES  4

`endif

// [hw/pcg_pkg.sv]
package pcg_pkg;
  // Link operating mode as found by the pin activity detector
  typedef enum logic [1:0] {
    pcg_mode_none,
    pcg_mode_hwy,
    pcg_mode_bus
  } pcg_mode_t;
endpackage

// [hw/pcg_slot_if.sv]
`timescale 1ns/1ps
// ------------------------------------------------------------
// Bundle between the port top and one timeslot engine
// ------------------------------------------------------------
interface pcg_slot_if #(parameter int PW = 10);
  logic          bit_en;   // Advance one bit period
  logic [PW-1:0] bit_cnt;  // Bit position since frame sync
  logic [PW-1:0] start;    // First bit position of the slot
  logic          wide;     // 16-bit linear burst when high
  logic          tx_en;    // Slot drives the line
  logic          rx_en;    // Slot captures the line
  logic [15:0]   tx_word;  // Word to send
  logic          rx_bit;   // Synchronised line level
  logic          tx_bit;   // Bit being sent
  logic          tx_act;   // Burst in progress
  logic [15:0]   rx_word;  // Last word received
  modport slot (input bit_en, bit_cnt, start, wide, tx_en, rx_en, tx_word, rx_bit,
                output tx_bit, tx_act, rx_word);
  modport port (output bit_en, bit_cnt, start, wide, tx_en, rx_en, tx_word, rx_bit,
                input tx_bit, tx_act, rx_word);
endinterface

// [hw/pcg_slot.sv]
`timescale 1ns/1ps
// ------------------------------------------------------------
// One timeslot engine: shifts one burst each way per frame
// ------------------------------------------------------------
module pcg_slot (
  input wire logic link_clk,
  input wire logic link_rst,
  pcg_slot_if.slot s
);
  logic [15:0] tx_sh_q;   // Transmit shifter, MSB leaves first
  logic [15:0] rx_sh_q;   // Receive shifter
  logic [4:0]  rem_q;     // Bits still to go in the burst
  logic        rx_act_q;  // Capture running
  logic        hit;       // Slot starts at this bit
  logic [15:0] load;      // Word aligned to the top of the shifter

  assign hit  = s.bit_en && (s.bit_cnt == s.start);
  assign load = s.wide ? s.tx_word : {s.tx_word[7:0], 8'h00};

  // Burst sequencing; a new frame restarts a slot cleanly
  always_ff @(posedge link_clk or posedge link_rst) begin
    if (link_rst) begin
      tx_sh_q   <= 16'h0000;
      rx_sh_q   <= 16'h0000;
      rem_q     <= 5'h00;
      rx_act_q  <= 1'b0;
      s.tx_bit  <= 1'b0;
      s.tx_act  <= 1'b0;
      s.rx_word <= 16'h0000;
    end else if (hit) begin
      tx_sh_q  <= {load[14:0], 1'b0};
      s.tx_bit <= load[15];
      s.tx_act <= s.tx_en;
      rx_sh_q  <= {15'h0000, s.rx_bit};
      rx_act_q <= s.rx_en;
      rem_q    <= s.wide ? 5'd15 : 5'd7;
    end else if (s.bit_en && rem_q != 5'h00) begin
      tx_sh_q  <= {tx_sh_q[14:0], 1'b0};
      s.tx_bit <= tx_sh_q[15];
      rx_sh_q  <= {rx_sh_q[14:0], s.rx_bit};
      rem_q    <= rem_q - 5'd1;
    end else if (s.bit_en) begin
      // Burst over: release the line and publish the word
      s.tx_act <= 1'b0;
      rx_act_q <= 1'b0;
      if (rx_act_q) begin
        s.rx_word <= s.wide ? rx_sh_q : {8'h00, rx_sh_q[7:0]};
      end
    end
  end
endmodule

// [hw/pcg_mode_det.sv]
`timescale 1ns/1ps
`include "pcg_map.svh"
// ------------------------------------------------------------
// Pin activity detector: which shared pin carries the clock
// ------------------------------------------------------------
module pcg_mode_det #(
  parameter int WIN_CYC = `PCG_DET_WIN_CYC
) (
  input  wire logic         sys_clk,
  input  wire logic         sys_rst,
  input  wire logic         pin_a,   // Bit clock in highway, sync in bus mode
  input  wire logic         pin_b,   // Sync in highway, bus clock in bus mode
  output pcg_pkg::pcg_mode_t mode
);
  localparam int WW = $clog2(WIN_CYC + 1);

  if (WIN_CYC < 2) begin : g_chk
    $error("pcg_mode_det: window too short");
  end

  logic [2:0]    a_q;    // Two-stage sync then edge history
  logic [2:0]    b_q;
  logic [WW-1:0] win_q;  // Observation window counter
  logic [7:0]    na_q;   // Saturating rising-edge counts
  logic [7:0]    nb_q;
  logic          rise_a;
  logic          rise_b;
  logic          win_end;
  logic          a_fast;
  logic          b_fast;
  logic          a_sync;
  logic          b_sync;

  assign rise_a  = a_q[1] & ~a_q[2];
  assign rise_b  = b_q[1] & ~b_q[2];
  assign win_end = (win_q == WW'(WIN_CYC - 1));
  assign a_fast  = na_q >= 8'(`PCG_MIN_CLK_EDGES);
  assign b_fast  = nb_q >= 8'(`PCG_MIN_CLK_EDGES);
  assign a_sync  = (na_q != 8'h00) && (na_q <= 8'(`PCG_MAX_FS_EDGES));
  assign b_sync  = (nb_q != 8'h00) && (nb_q <= 8'(`PCG_MAX_FS_EDGES));

  // Count edges per window, then classify the pin pair
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      a_q   <= 3'h0;
      b_q   <= 3'h0;
      win_q <= '0;
      na_q  <= 8'h00;
      nb_q  <= 8'h00;
      mode  <= pcg_pkg::pcg_mode_none;
    end else begin
      a_q   <= {a_q[1:0], pin_a};
      b_q   <= {b_q[1:0], pin_b};
      win_q <= win_end ? '0 : win_q + WW'(1);
      if (win_end) begin
        na_q <= 8'h00;
        nb_q <= 8'h00;
        if (a_fast && b_sync) begin
          mode <= pcg_pkg::pcg_mode_hwy;
        end else if (b_fast && a_sync) begin
          mode <= pcg_pkg::pcg_mode_bus;
        end else begin
          mode <= pcg_pkg::pcg_mode_none;
        end
      end else begin
        if (rise_a && na_q != 8'hFF) na_q <= na_q + 8'h01;
        if (rise_b && nb_q != 8'hFF) nb_q <= nb_q + 8'h01;
      end
    end
  end
endmodule

// [hw/pcg_highway_port.sv]
// The plain strobed port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`include "pcg_map.svh"
// ------------------------------------------------------------
// Serial voice port: highway and bus modes, four channels
// ------------------------------------------------------------
module pcg_highway_port #(
  parameter int NCH     = 4,                  // Voice channels
  parameter int PW      = 10,                 // Bit position width
  parameter int WIN_CYC = `PCG_DET_WIN_CYC    // Mode detect window
) (
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  input  wire logic        link_clk,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  input  wire logic        sync_or_bus_clock_pin,
  input  wire logic        bit_clock_or_sync_pin,
  input  wire logic        receive_line_primary,
  input  wire logic        receive_line_secondary,
  output logic             transmit_line_primary_o,
  output logic             transmit_line_primary_oe,
  output logic             transmit_line_secondary_o,
  output logic             transmit_line_secondary_oe,
  output logic             slot_indicator_primary_o,
  output logic             slot_indicator_primary_oe,
  output logic             slot_indicator_secondary_o,
  output logic             slot_indicator_secondary_oe
);
  localparam int NS = NCH + 1;  // Voice slots plus the control slot

  if (NCH < 1 || NCH > 4 || PW < 5 || PW > 12) begin : g_chk
    $error("pcg_highway_port: unsupported NCH or PW");
  end

  // ------------------------------------------------------------
  // Software registers (sys_clk)
  // ------------------------------------------------------------
  logic [15:0]   cfg_q;            // Mode and option bits
  logic [PW-1:0] pos_q [NS];       // Slot starts, last one is control
  logic [15:0]   txw_q [NCH];      // Voice words to send
  logic [7:0]    sig_q;            // Signaling byte to send
  logic [15:0]   rxw_q [NCH];      // Voice words received last frame
  logic [7:0]    ctl_rx_q;         // Control byte received last frame
  logic [7:0]    frames_q;         // Frames seen, wraps

  // Hand-over copies, only changed just after a frame mark
  logic [15:0]   x_cfg_q;
  logic [PW-1:0] x_pos_q [NS];
  logic [15:0]   x_tx_q  [NS];

  pcg_pkg::pcg_mode_t mode;
  logic          frm_tgl_q;        // Flips once per frame, link side
  logic [2:0]    ft_q;             // Frame toggle sync plus history
  logic          frm_evt;
  logic [3:0]    grp;
  logic [1:0]    ch;
  logic          wr_cfg;
  logic          wr_cpos;
  logic          wr_sig;
  logic          wr_vpos;
  logic          wr_vtx;
  logic          ch_ok;
  logic [31:0]   rd_val;
  logic [15:0]   rx_words [NS];    // Link-domain results, read at frame mark

  assign grp     = reg_addr[7:4];
  assign ch      = reg_addr[3:2];
  assign ch_ok   = (32'(ch) < NCH) && (reg_addr[1:0] == 2'b00);
  assign wr_cfg  = reg_wr && reg_addr == `PCG_REG_CFG;
  assign wr_cpos = reg_wr && reg_addr == `PCG_REG_CTRL_POS;
  assign wr_sig  = reg_wr && reg_addr == `PCG_REG_SIG_TX;
  assign wr_vpos = reg_wr && grp == `PCG_GRP_VPOS && ch_ok;
  assign wr_vtx  = reg_wr && grp == `PCG_GRP_VTX && ch_ok;
  assign frm_evt = ft_q[1] ^ ft_q[2];

  // Read selection; holes read as zero
  assign rd_val =
    (reg_addr == `PCG_REG_CFG)                ? {16'h0000, cfg_q} :
    (reg_addr == `PCG_REG_STAT)               ? {16'h0000, frames_q, 6'h00, mode} :
    (reg_addr == `PCG_REG_CTRL_POS)           ? 32'(pos_q[NCH]) :
    (reg_addr == `PCG_REG_SIG_TX)             ? {24'h000000, sig_q} :
    (reg_addr == `PCG_REG_CTRL_RX)            ? {24'h000000, ctl_rx_q} :
    (grp == `PCG_GRP_VPOS && ch_ok)           ? 32'(pos_q[ch]) :
    (grp == `PCG_GRP_VTX && ch_ok)            ? {16'h0000, txw_q[ch]} :
    (grp == `PCG_GRP_VRX && ch_ok)            ? {16'h0000, rxw_q[ch]} :
                                                32'h0000_0000;

  pcg_mode_det #(
    .WIN_CYC (WIN_CYC)
  ) u_det (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .pin_a   (bit_clock_or_sync_pin),
    .pin_b   (sync_or_bus_clock_pin),
    .mode    (mode)
  );

  // Register writes and read data, answered the next cycle
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cfg_q     <= `PCG_CFG_RESET;
      sig_q     <= 8'h00;
      reg_rdata <= 32'h0000_0000;
      for (int i = 0; i < NS; i++) pos_q[i] <= '0;
      for (int i = 0; i < NCH; i++) txw_q[i] <= 16'h0000;
    end else begin
      reg_rdata <= reg_rd ? rd_val : 32'h0000_0000;
      if (wr_cfg) cfg_q <= reg_wdata[15:0];
      if (wr_sig) sig_q <= reg_wdata[7:0];
      if (wr_cpos) pos_q[NCH] <= reg_wdata[PW-1:0];
      if (wr_vpos) pos_q[ch] <= reg_wdata[PW-1:0];
      if (wr_vtx) txw_q[ch] <= reg_wdata[15:0];
    end
  end

  // Frame mark: capture results and refresh the hand-over copies.
  // The link side reads the copies only at the next frame sync,
  // a full frame later, so they are stable when it samples them.
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ft_q     <= 3'h0;
      frames_q <= 8'h00;
      ctl_rx_q <= 8'h00;
      x_cfg_q  <= `PCG_CFG_RESET;
      for (int i = 0; i < NS; i++) begin
        x_pos_q[i] <= '0;
        x_tx_q[i]  <= 16'h0000;
      end
      for (int i = 0; i < NCH; i++) rxw_q[i] <= 16'h0000;
    end else begin
      ft_q <= {ft_q[1:0], frm_tgl_q};
      if (frm_evt) begin
        frames_q <= frames_q + 8'h01;
        ctl_rx_q <= rx_words[NCH][7:0];
        x_cfg_q  <= cfg_q;
        x_tx_q[NCH] <= {8'h00, sig_q};
        for (int i = 0; i < NS; i++) x_pos_q[i] <= pos_q[i];
        for (int i = 0; i < NCH; i++) begin
          rxw_q[i]  <= rx_words[i];
          x_tx_q[i] <= txw_q[i];
        end
      end
    end
  end

  // ------------------------------------------------------------
  // Link domain (link_clk)
  // ------------------------------------------------------------
  logic [1:0]    lrst_q;           // Reset release synchroniser
  logic          link_rst;
  logic [3:0]    in_m1_q;          // Pin synchroniser, first stage
  logic [3:0]    in_s_q;           // Pin synchroniser, second stage
  logic [1:0]    md_m1_q;          // Mode level synchroniser
  logic [1:0]    md_s_q;
  logic          fs_prev_q;
  logic          phase_q;          // Half-rate phase for fast bus clock
  logic [PW-1:0] bit_cnt_q;        // Bit position since frame sync
  logic [NS-1:0] slot_act;         // Per-slot burst flags
  logic [NS-1:0] slot_bit;         // Per-slot line bits
  logic [15:0]   l_cfg_q;          // Frame-stable copies
  logic [PW-1:0] l_pos_q [NS];
  logic [15:0]   l_tx_q  [NS];
  logic          hwy;
  logic          bus;
  logic          fs_sel;
  logic          fs_edge;
  logic          bit_en;
  logic          drive_ok;
  logic          act_p;
  logic          act_s;
  logic          bit_p;
  logic          bit_s;
  logic          ind_p;
  logic          ind_s;

  assign link_rst = lrst_q[1];
  assign hwy      = md_s_q[0];
  assign bus      = md_s_q[1];
  // Sync sits on the pin that is not the clock in each mode
  assign fs_sel   = bus ? in_s_q[0] : in_s_q[1];
  assign fs_edge  = fs_sel & ~fs_prev_q & (hwy | bus);
  // Bus data runs at half a 4 MHz bus clock, full rate at 2 MHz
  assign bit_en   = ~(bus & l_cfg_q[`PCG_CFG_DCL_X2]) | phase_q;
  assign drive_ok = ~l_cfg_q[`PCG_CFG_INACTIVE] & (hwy | bus);

  always_ff @(posedge link_clk or posedge sys_rst) begin
    if (sys_rst) lrst_q <= 2'b11;
    else         lrst_q <= {lrst_q[0], 1'b0};
  end

  // Pin and mode synchronisers; pins order: a, b, rx primary, rx secondary
  always_ff @(posedge link_clk or posedge link_rst) begin
    if (link_rst) begin
      in_m1_q <= 4'h0;
      in_s_q  <= 4'h0;
      md_m1_q <= 2'b00;
      md_s_q  <= 2'b00;
    end else begin
      in_m1_q <= {receive_line_secondary, receive_line_primary,
                  sync_or_bus_clock_pin, bit_clock_or_sync_pin};
      in_s_q  <= in_m1_q;
      md_m1_q <= {mode == pcg_pkg::pcg_mode_bus, mode == pcg_pkg::pcg_mode_hwy};
      md_s_q  <= md_m1_q;
    end
  end

  // Frame timing and per-frame loading of settings
  always_ff @(posedge link_clk or posedge link_rst) begin
    if (link_rst) begin
      fs_prev_q <= 1'b0;
      phase_q   <= 1'b0;
      bit_cnt_q <= '1;
      frm_tgl_q <= 1'b0;
      l_cfg_q   <= `PCG_CFG_RESET;
      for (int i = 0; i < NS; i++) begin
        l_pos_q[i] <= '1;
        l_tx_q[i]  <= 16'h0000;
      end
    end else begin
      fs_prev_q <= fs_sel;
      if (fs_edge) begin
        bit_cnt_q <= '0;
        phase_q   <= 1'b1;
        frm_tgl_q <= ~frm_tgl_q;
        l_cfg_q   <= x_cfg_q;
        for (int i = 0; i < NS; i++) begin
          l_pos_q[i] <= x_pos_q[i];
          l_tx_q[i]  <= x_tx_q[i];
        end
      end else begin
        phase_q <= ~phase_q;
        if (bit_en && bit_cnt_q != '1) bit_cnt_q <= bit_cnt_q + PW'(1);
      end
    end
  end

  // ------------------------------------------------------------
  // Timeslot engines: voice channels, then the control slot
  // ------------------------------------------------------------
  pcg_slot_if #(.PW(PW)) sif [NS] ();

  for (genvar i = 0; i < NS; i++) begin : g_slot
    localparam bit IS_CTL = (i == NCH);
    logic sec;  // Slot uses the secondary lines
    // Bus mode keeps every slot on the primary lines
    if (IS_CTL) begin : g_c
      assign sec = 1'b0;
      assign sif[i].wide  = 1'b0;
      assign sif[i].tx_en = l_cfg_q[`PCG_CFG_CTRL_EN]
                          & ~l_cfg_q[`PCG_CFG_DISC];
      assign sif[i].rx_en = l_cfg_q[`PCG_CFG_CTRL_EN]
                          & l_cfg_q[`PCG_CFG_CTRL_KIND];
    end else begin : g_v
      assign sec = l_cfg_q[`PCG_CFG_SEC_LSB + i] & hwy;
      assign sif[i].wide  = l_cfg_q[`PCG_CFG_LIN_LSB + i];
      assign sif[i].tx_en = 1'b1;
      assign sif[i].rx_en = 1'b1;
    end
    assign sif[i].bit_en  = bit_en;
    assign sif[i].bit_cnt = bit_cnt_q;
    assign sif[i].start   = l_pos_q[i];
    assign sif[i].tx_word = l_tx_q[i];
    assign sif[i].rx_bit  = sec ? in_s_q[3] : in_s_q[2];
    assign rx_words[i]    = sif[i].rx_word;
    assign slot_act[i]    = sif[i].tx_act;
    assign slot_bit[i]    = sif[i].tx_bit;

    pcg_slot u_slot (
      .link_clk (link_clk),
      .link_rst (link_rst),
      .s        (sif[i])
    );
  end

  // Merge slot outputs onto the two lines; slots must not overlap
  always_comb begin
    act_p = 1'b0;
    act_s = 1'b0;
    bit_p = 1'b0;
    bit_s = 1'b0;
    ind_p = 1'b0;
    ind_s = 1'b0;
    for (int i = 0; i < NS; i++) begin
      if (slot_act[i]) begin
        if (i < NCH && l_cfg_q[`PCG_CFG_SEC_LSB + i] && hwy) begin
          act_s = 1'b1;
          bit_s = bit_s | slot_bit[i];
          ind_s = 1'b1;
        end else begin
          act_p = 1'b1;
          bit_p = bit_p | slot_bit[i];
          ind_p = ind_p | (i < NCH);
        end
      end
    end
  end

  // ------------------------------------------------------------
  // Pin drivers
  // ------------------------------------------------------------
  assign transmit_line_primary_o     = bit_p;
  assign transmit_line_primary_oe    = act_p & drive_ok;
  assign transmit_line_secondary_o   = bit_s;
  assign transmit_line_secondary_oe  = act_s & drive_ok;
  // Open drain: only ever pulls low, and only in highway mode
  assign slot_indicator_primary_o    = 1'b0;
  assign slot_indicator_primary_oe   = ind_p & drive_ok & hwy;
  assign slot_indicator_secondary_o  = 1'b0;
  assign slot_indicator_secondary_oe = ind_s & drive_ok & hwy;
endmodule

// [test/pcg_highway_port_monitor.sv]
`timescale 1ns/1ps
`include "pcg_map.svh"
// ----------
// Port checker
// ----------
module pcg_highway_port_monitor (
  input wire logic        sys_clk,
  input wire logic        sys_rst,
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic        transmit_line_primary_oe,
  input wire logic        transmit_line_secondary_oe,
  input wire logic        slot_indicator_primary_o,
  input wire logic        slot_indicator_primary_oe,
  input wire logic        slot_indicator_secondary_o,
  input wire logic        slot_indicator_secondary_oe
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  logic [15:0] cfg_q;  // Shadow of the configuration word
  logic [9:0]  idle_q; // Cycles spent inactive, saturating
  logic [5:0]  run_q;  // Cycles the primary line has driven
  wire         cfg_wr = reg_wr && reg_addr == `PCG_REG_CFG;
  // Sampling the link lines here is safe: link edges never coincide with rising sys edges
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cfg_q  <= `PCG_CFG_RESET;
      idle_q <= 10'h000;
      run_q  <= 6'h00;
    end else begin
      cfg_q  <= cfg_wr ? reg_wdata[15:0] : cfg_q;
      idle_q <= cfg_q[2] ? idle_q + {9'h000, idle_q != 10'h3FF} : 10'h000;
      run_q  <= transmit_line_primary_oe ? run_q + {5'h00, run_q != 6'h3F} : 6'h00;
    end
  end
  property p_rd_idle; !$past(reg_rd) |-> reg_rdata == 32'h0000_0000; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not zero when idle");
  property p_cfg_back; reg_rd && reg_addr == `PCG_REG_CFG |=> reg_rdata[15:0] == cfg_q; endproperty
  a_cfg_back: assert property (p_cfg_back) else $error("config readback differs");
  property p_ind_low; !slot_indicator_primary_o && !slot_indicator_secondary_o; endproperty
  a_ind_low: assert property (p_ind_low) else $error("indicator driven high");
  property p_ind_a; slot_indicator_primary_oe |-> transmit_line_primary_oe; endproperty
  a_ind_a: assert property (p_ind_a) else $error("primary indicator without data");
  property p_ind_b; slot_indicator_secondary_oe |-> transmit_line_secondary_oe; endproperty
  a_ind_b: assert property (p_ind_b) else $error("secondary indicator without data");
  property p_burst_a; $fell(transmit_line_primary_oe) |-> run_q >= 6'h2C; endproperty
  a_burst_a: assert property (p_burst_a) else $error("primary burst too short");
  property p_burst_b; $rose(transmit_line_secondary_oe) |-> transmit_line_secondary_oe[*8]; endproperty
  a_burst_b: assert property (p_burst_b) else $error("secondary burst too short");
  property p_quiet; idle_q == 10'h3FF |-> !transmit_line_primary_oe && !transmit_line_secondary_oe; endproperty
  a_quiet: assert property (p_quiet) else $error("line driven while inactive");
  c_ctrl_rd: cover property (reg_rd && reg_addr == `PCG_REG_CTRL_RX);
  c_burst_a: cover property ($rose(transmit_line_primary_oe));
  c_burst_b: cover property ($rose(transmit_line_secondary_oe));
endmodule

// [test/pcg_hwy_ctrl_model.sv]
`timescale 1ns/1ps
// ----------
// Highway controller: free bit clock, frame sync, receive data, capture
// ----------
module pcg_hwy_ctrl_model (
  input  wire logic [63:0] rx_frame,   // Receive bits, MSB at position 0
  input  wire logic        tx_a,
  input  wire logic        tx_a_oe,
  input  wire logic        tx_b,
  input  wire logic        tx_b_oe,
  output logic             link_clk,   // 30 ns bit clock
  output logic             frame_sync,
  output logic             rx_a,
  output logic             rx_b,
  output logic [63:0]      got_a,      // Bits driven in the last frame
  output logic [63:0]      got_b,
  output logic [6:0]       cnt_a,      // Number of bits driven
  output logic [6:0]       cnt_b
);
  logic [5:0]  pos_q;  // Period within the 64-period frame
  logic [63:0] sh_a_q;
  logic [63:0] sh_b_q;
  logic [6:0]  n_a_q;
  logic [6:0]  n_b_q;
  initial begin
    {pos_q, frame_sync, rx_a, rx_b, got_a, got_b, cnt_a, cnt_b} = '0;
    {sh_a_q, sh_b_q, n_a_q, n_b_q} = '0;
    link_clk = 1'b0;
    forever #15 link_clk = ~link_clk;
  end
  // Falling-edge drive keeps sync and data settled at the device edge
  always @(negedge link_clk) begin
    pos_q      <= pos_q + 6'h01;
    frame_sync <= pos_q == 6'h00;
    rx_a       <= rx_frame[6'h00 - pos_q];
    rx_b       <= ~rx_frame[6'h00 - pos_q];
    if (pos_q == 6'h00) begin
      {got_a, got_b, cnt_a, cnt_b} <= {sh_a_q, sh_b_q, n_a_q, n_b_q};
      {sh_a_q, sh_b_q, n_a_q, n_b_q} <= '0;
    end else begin
      if (tx_a_oe) {sh_a_q, n_a_q} <= {sh_a_q[62:0], tx_a, n_a_q + 7'h01};
      if (tx_b_oe) {sh_b_q, n_b_q} <= {sh_b_q[62:0], tx_b, n_b_q + 7'h01};
    end
  end
endmodule

// [test/tb_pcg_highway_port.sv]
`timescale 1ns/1ps
`include "pcg_map.svh"
module tb_pcg_highway_port;
  logic        sys_clk;
  logic        sys_rst;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [31:0] reg_rdata;
  logic        link_clk;
  logic        sync_pin;
  logic        rx_a;
  logic        rx_b;
  wire  [7:0]  tx;        // Line data, enables and indicators
  logic [63:0] rx_frame;
  logic [63:0] got_a;
  logic [63:0] got_b;
  logic [6:0]  cnt_a;
  logic [6:0]  cnt_b;
  logic [31:0] d;         // Last word read
  logic [31:0] d0;
  int          num_errors = 0;
  int          checked = 0;
  int          cycles = 0;
  pcg_highway_port #(.WIN_CYC(500)) pcg_highway_port_inst (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .link_clk(link_clk), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .sync_or_bus_clock_pin(sync_pin), .bit_clock_or_sync_pin(link_clk),
    .receive_line_primary(rx_a), .receive_line_secondary(rx_b),
    .transmit_line_primary_o(tx[0]), .transmit_line_primary_oe(tx[1]),
    .transmit_line_secondary_o(tx[2]), .transmit_line_secondary_oe(tx[3]),
    .slot_indicator_primary_o(tx[4]), .slot_indicator_primary_oe(tx[5]),
    .slot_indicator_secondary_o(tx[6]), .slot_indicator_secondary_oe(tx[7]));
  pcg_hwy_ctrl_model pcg_hwy_ctrl_model_inst (
    .rx_frame(rx_frame), .tx_a(tx[0]), .tx_a_oe(tx[1]), .tx_b(tx[2]), .tx_b_oe(tx[3]),
    .link_clk(link_clk), .frame_sync(sync_pin), .rx_a(rx_a), .rx_b(rx_b),
    .got_a(got_a), .got_b(got_b), .cnt_a(cnt_a), .cnt_b(cnt_b));
  task automatic conclude;
    if (num_errors == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    checked++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr    <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge sys_clk);
    reg_rd   <= 1'b0;
    #1 d = reg_rdata;
  endtask
  // Settings land at the second frame, so callers wait four
  task automatic frames(input int n);
    repeat (n) @(posedge sync_pin);
    repeat (40) @(posedge sys_clk);
  endtask
  task automatic t_mode;
    rd(`PCG_REG_CFG);
    chk(d, 32'h0000_0004);
    rd(8'hFC);
    chk(d, 32'h0000_0000);
    frames(3);
    rd(`PCG_REG_STAT);
    chk(d[1:0], 2'h1);
    chk(tx & 8'hAA, 8'h00);
    d0 = d;
    frames(2);
    rd(`PCG_REG_STAT);
    chk(8'(d[15:8] - d0[15:8]), 8'h02);
  endtask
  task automatic t_voice;
    for (int ch = 0; ch < 4; ch++) begin
      wr(8'h20 + 8'(4 * ch), 32'(8 + 8 * ch));
      wr(8'h30 + 8'(4 * ch), 32'h0000_C3A5 + 32'(ch));
    end
    wr(`PCG_REG_CFG, 32'h0000_0000);
    frames(4);
    chk({cnt_b, cnt_a}, {7'h00, 7'h20});
    chk(got_a[31:0], 32'hA5A6_A7A8);
    rd(8'h40);
    chk(d[7:0], rx_frame[55:48]);
    wr(`PCG_REG_CFG, 32'h0000_1100);
    frames(4);
    chk({cnt_b, cnt_a}, {7'h10, 7'h18});
    chk({got_b[15:0], got_a[23:0]}, 40'hC3A5_A6A7A8);
    rd(8'h40);
    chk(d[15:0], 16'(~rx_frame[55:40]));
  endtask
  task automatic t_sig;
    wr(`PCG_REG_CTRL_POS, 32'h0000_0030);
    wr(`PCG_REG_SIG_TX, 32'h0000_005A);
    wr(`PCG_REG_CFG, 32'h0000_0003);
    frames(4);
    chk(got_a[39:0], 40'hA5A6_A7A8_5A);
    rd(`PCG_REG_CTRL_RX);
    chk(d[7:0], rx_frame[15:8]);
    d0 = d;
    wr(`PCG_REG_CFG, 32'h0000_0001);
    // Capture must be off before the line data changes
    frames(2);
    rx_frame <= ~rx_frame;
    frames(4);
    chk(cnt_a, 7'h28);
    rd(`PCG_REG_CTRL_RX);
    chk(d, d0);
    rd(8'h40);
    chk(d[7:0], rx_frame[55:48]);
    wr(`PCG_REG_CFG, 32'h0000_0009);
    frames(4);
    chk(cnt_a, 7'h20);
    wr(`PCG_REG_CFG, 32'h0000_0004);
    frames(4);
    chk({cnt_b, cnt_a}, 14'h0000);
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  // Run needs about 12k cycles; the ceiling leaves ample margin
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 30000) begin
      num_errors++;
      conclude();
    end
  end
  initial begin
    {sys_rst, reg_addr, reg_wdata, reg_wr, reg_rd} = {1'b1, 42'h0};
    rx_frame = 64'h3C96_A50F_E178_D24B;
    repeat (12) @(posedge sys_clk);
    sys_rst <= 1'b0;
    t_mode();
    t_voice();
    t_sig();
    conclude();
  end
endmodule
bind pcg_highway_port pcg_highway_port_monitor pcg_highway_port_monitor_inst (
  .sys_clk(sys_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .transmit_line_primary_oe(transmit_line_primary_oe),
  .transmit_line_secondary_oe(transmit_line_secondary_oe),
  .slot_indicator_primary_o(slot_indicator_primary_o),
  .slot_indicator_primary_oe(slot_indicator_primary_oe),
  .slot_indicator_secondary_o(slot_indicator_secondary_o),
  .slot_indicator_secondary_oe(slot_indicator_secondary_oe));
